// ---- hdl/balu_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "balu_regs.svh"

// Behaviour
// - add operand into accumulator in one cycle; reg/indirect 1 byte, direct/imm 2
// - add operand plus carry into accumulator in one cycle; same byte lengths
// - subtract operand and borrow from accumulator in one cycle; reg 1, direct 2 bytes
// - increment accumulator or operand in one cycle; direct form 2 bytes, others 1
// - decrement accumulator or operand in one cycle; direct form 2 bytes, others 1
// - multiply accumulator by B, one byte, four cycles
// - divide accumulator by B, one byte, four cycles
// - decimal-adjust accumulator after addition, one byte, one cycle
// - AND operand into accumulator in one cycle; reg/indirect 1, direct/imm 2 bytes
// - AND into direct byte: acc form 2 bytes/1 cycle, immediate 3 bytes/2 cycles
// - OR operand into accumulator in one cycle; reg/indirect 1, direct/imm 2 bytes
// - OR into direct byte: acc form 2 bytes/1 cycle, immediate 3 bytes/2 cycles
// - XOR bank register into accumulator, one byte, one cycle
module balu_core (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // instruction issue
  input wire logic issueValid,
  output logic issueReady,
  input wire balu_pkg::balu_op_type issueOp,
  input wire balu_pkg::balu_src_type issueSrc,
  input wire balu_pkg::balu_dst_type issueDst,
  input wire logic [7:0] operandByte,
  input wire logic [7:0] immByte,
  // completion
  output logic doneValid,
  output logic [1:0] doneLength,
  output logic [2:0] doneCycles,
  output logic resultWrite,
  output logic [7:0] resultByte,
  // architectural state
  output logic [7:0] accOut,
  output logic [7:0] bRegOut,
  output logic [15:0] dataPointerOut,
  output logic carryOut,
  output logic auxCarryOut,
  output logic overflowOut
);

  // ***********************************
  // state registers
  // ***********************************
  balu_pkg::balu_state_type state_r, state_nxt;
  balu_pkg::balu_op_type op_r, op_nxt;
  balu_pkg::balu_src_type src_r, src_nxt;
  balu_pkg::balu_dst_type dst_r, dst_nxt;
  logic [7:0] opnd_r, opnd_nxt;
  logic [7:0] imm_r, imm_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [2:0] need_r, need_nxt;
  logic [1:0] len_r, len_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic [7:0] b_r, b_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic cy_r, cy_nxt;
  logic ac_r, ac_nxt;
  logic ov_r, ov_nxt;
  logic done_r, done_nxt;
  logic wr_r, wr_nxt;
  logic [7:0] res_r, res_nxt;

  // ***********************************
  // datapath helpers
  // ***********************************
  logic [7:0] srcVal;
  logic [8:0] sum9;
  logic [4:0] sumLo;
  logic [8:0] dif9;
  logic [4:0] difLo;
  logic [15:0] prod16;
  logic [7:0] quot;
  logic [7:0] remd;
  logic [8:0] bcdAdj;
  logic [7:0] opndSel;
  logic addCin;

  // operand mux: acc-as-source feeds the logic ops into a direct byte
  always_comb begin
    case (src_r)
      balu_pkg::BALU_SRC_IMM: srcVal = imm_r;
      balu_pkg::BALU_SRC_ACC: srcVal = acc_r;
      default: srcVal = opnd_r;
    endcase
    // immediate logic into a direct byte combines with the stored byte
    opndSel = (dst_r == balu_pkg::BALU_DST_OPERAND) ? opnd_r : acc_r;
    addCin = (op_r == balu_pkg::BALU_OP_SUM_WITH_CARRY_IN) && cy_r;
    sum9 = {1'b0, acc_r} + {1'b0, srcVal} + {8'h00, addCin};
    sumLo = {1'b0, acc_r[3:0]} + {1'b0, srcVal[3:0]} + {4'h0, addCin};
    dif9 = {1'b0, acc_r} - {1'b0, srcVal} - {8'h00, cy_r};
    difLo = {1'b0, acc_r[3:0]} - {1'b0, srcVal[3:0]} - {4'h0, cy_r};
    prod16 = acc_r * b_r;
    // divide by zero leaves quotient and remainder undefined; zero them
    quot = (b_r == 8'h00) ? 8'h00 : acc_r / b_r;
    remd = (b_r == 8'h00) ? 8'h00 : acc_r % b_r;
    bcdAdj = {1'b0, acc_r};
    if (ac_r || (acc_r[3:0] > 4'h9)) begin
      bcdAdj = bcdAdj + 9'h006;
    end
    if (cy_r || bcdAdj[8] || (bcdAdj[7:4] > 4'h9)) begin
      bcdAdj = bcdAdj + 9'h060;
    end
  end

  // handshake: one instruction in flight, accepted only when idle
  assign issueReady = (state_r == balu_pkg::BALU_ST_IDLE);

  // ***********************************
  // sequencer and execute
  // ***********************************
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    opnd_nxt = opnd_r;
    imm_nxt = imm_r;
    cnt_nxt = cnt_r;
    need_nxt = need_r;
    len_nxt = len_r;
    acc_nxt = acc_r;
    b_nxt = b_r;
    ptr_nxt = ptr_r;
    cy_nxt = cy_r;
    ac_nxt = ac_r;
    ov_nxt = ov_r;
    done_nxt = 1'b0;
    wr_nxt = 1'b0;
    res_nxt = res_r;
    case (state_r)
      balu_pkg::BALU_ST_IDLE: begin
        if (issueValid) begin
          state_nxt = balu_pkg::BALU_ST_BUSY;
          op_nxt = issueOp;
          src_nxt = issueSrc;
          dst_nxt = issueDst;
          opnd_nxt = operandByte;
          imm_nxt = immByte;
          cnt_nxt = 3'h1;
          // length: direct/immediate take a second byte
          len_nxt = (issueSrc == balu_pkg::BALU_SRC_DIRECT ||
                     issueSrc == balu_pkg::BALU_SRC_IMM) ? `BALU_LEN_TWO : `BALU_LEN_ONE;
          if (issueDst == balu_pkg::BALU_DST_OPERAND && issueSrc != balu_pkg::BALU_SRC_BANK &&
              issueSrc != balu_pkg::BALU_SRC_INDIRECT) begin
            len_nxt = (issueSrc == balu_pkg::BALU_SRC_IMM) ? `BALU_LEN_THREE : `BALU_LEN_TWO;
          end
          need_nxt = `BALU_CYC_ONE;
          case (issueOp)
            balu_pkg::BALU_OP_INCPTR: need_nxt = `BALU_CYC_TWO;
            balu_pkg::BALU_OP_PROD, balu_pkg::BALU_OP_DIVIDE: begin
              need_nxt = `BALU_CYC_FOUR;
              // core hands B over on the operand lane; without this B could never leave zero
              b_nxt = operandByte;
            end
            default: begin
              if (issueDst == balu_pkg::BALU_DST_OPERAND && issueSrc == balu_pkg::BALU_SRC_IMM) begin
                need_nxt = `BALU_CYC_TWO;
              end
            end
          endcase
          if (issueOp == balu_pkg::BALU_OP_INCPTR || issueOp == balu_pkg::BALU_OP_PROD ||
              issueOp == balu_pkg::BALU_OP_DIVIDE || issueOp == balu_pkg::BALU_OP_BCD) begin
            len_nxt = `BALU_LEN_ONE;
          end
        end
      end
      balu_pkg::BALU_ST_BUSY: begin
        if (cnt_r != need_r) begin
          cnt_nxt = cnt_r + 3'h1;
        end else begin
          state_nxt = balu_pkg::BALU_ST_IDLE;
          done_nxt = 1'b1;
          case (op_r)
            balu_pkg::BALU_OP_ADD, balu_pkg::BALU_OP_SUM_WITH_CARRY_IN: begin
              acc_nxt = sum9[7:0];
              cy_nxt = sum9[8];
              ac_nxt = sumLo[4];
              ov_nxt = (acc_r[7] == srcVal[7]) && (sum9[7] != acc_r[7]);
            end
            balu_pkg::BALU_OP_SUBTRACT_WITH_BORROW: begin
              acc_nxt = dif9[7:0];
              cy_nxt = dif9[8];
              ac_nxt = difLo[4];
              ov_nxt = (acc_r[7] != srcVal[7]) && (dif9[7] != acc_r[7]);
            end
            balu_pkg::BALU_OP_INC, balu_pkg::BALU_OP_STEPDN: begin
              // target is acc when source is acc, whatever dst is, else the operand
              if (src_r == balu_pkg::BALU_SRC_ACC) begin
                acc_nxt = (op_r == balu_pkg::BALU_OP_INC) ? acc_r + 8'h01 : acc_r - 8'h01;
              end else begin
                wr_nxt = 1'b1;
                res_nxt = (op_r == balu_pkg::BALU_OP_INC) ? opnd_r + 8'h01 : opnd_r - 8'h01;
              end
            end
            balu_pkg::BALU_OP_INCPTR: ptr_nxt = ptr_r + 16'h0001;
            balu_pkg::BALU_OP_PROD: begin
              acc_nxt = prod16[7:0];
              b_nxt = prod16[15:8];
              cy_nxt = 1'b0;
              ov_nxt = (prod16[15:8] != 8'h00);
            end
            balu_pkg::BALU_OP_DIVIDE: begin
              acc_nxt = quot;
              b_nxt = remd;
              cy_nxt = 1'b0;
              ov_nxt = (b_r == 8'h00);
            end
            balu_pkg::BALU_OP_BCD: begin
              acc_nxt = bcdAdj[7:0];
              cy_nxt = cy_r | bcdAdj[8];
            end
            balu_pkg::BALU_OP_AND, balu_pkg::BALU_OP_OR, balu_pkg::BALU_OP_XOR: begin
              // carry untouched on all logic ops
              if (op_r == balu_pkg::BALU_OP_AND) begin
                res_nxt = opndSel & srcVal;
              end else if (op_r == balu_pkg::BALU_OP_OR) begin
                res_nxt = opndSel | srcVal;
              end else begin
                res_nxt = opndSel ^ srcVal;
              end
              if (dst_r == balu_pkg::BALU_DST_OPERAND) begin
                wr_nxt = 1'b1;
              end else begin
                acc_nxt = (op_r == balu_pkg::BALU_OP_AND) ? (acc_r & srcVal) :
                          (op_r == balu_pkg::BALU_OP_OR) ? (acc_r | srcVal) : (acc_r ^ srcVal);
              end
            end
            default: ;
          endcase
        end
      end
      default: state_nxt = balu_pkg::BALU_ST_IDLE;
    endcase
  end

  // register everything; no enable, every edge
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= balu_pkg::BALU_ST_IDLE;
      op_r <= balu_pkg::BALU_OP_ADD;
      src_r <= balu_pkg::BALU_SRC_BANK;
      dst_r <= balu_pkg::BALU_DST_ACC;
      opnd_r <= 8'h00;
      imm_r <= 8'h00;
      cnt_r <= 3'h0;
      need_r <= 3'h0;
      len_r <= 2'h0;
      acc_r <= `BALU_ACC_RST;
      b_r <= `BALU_B_RST;
      ptr_r <= `BALU_DATA_POINTER_RST;
      cy_r <= 1'b0;
      ac_r <= 1'b0;
      ov_r <= 1'b0;
      done_r <= 1'b0;
      wr_r <= 1'b0;
      res_r <= 8'h00;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      opnd_r <= opnd_nxt;
      imm_r <= imm_nxt;
      cnt_r <= cnt_nxt;
      need_r <= need_nxt;
      len_r <= len_nxt;
      acc_r <= acc_nxt;
      b_r <= b_nxt;
      ptr_r <= ptr_nxt;
      cy_r <= cy_nxt;
      ac_r <= ac_nxt;
      ov_r <= ov_nxt;
      done_r <= done_nxt;
      wr_r <= wr_nxt;
      res_r <= res_nxt;
    end
  end

  // outputs straight from flip-flops
  assign doneValid = done_r;
  assign doneLength = len_r;
  assign doneCycles = need_r;
  assign resultWrite = wr_r;
  assign resultByte = res_r;
  assign accOut = acc_r;
  assign bRegOut = b_r;
  assign dataPointerOut = ptr_r;
  assign carryOut = cy_r;
  assign auxCarryOut = ac_r;
  assign overflowOut = ov_r;

endmodule

`default_nettype wire

// ---- hdl/balu_regs.svh ----
`ifndef BALU_REGS_SVH
`define BALU_REGS_SVH

// instruction lengths in bytes
`define BALU_LEN_ONE 2'h1
`define BALU_LEN_TWO 2'h2
`define BALU_LEN_THREE 2'h3

// execution times in machine cycles
`define BALU_CYC_ONE 3'h1
`define BALU_CYC_TWO 3'h2
`define BALU_CYC_FOUR 3'h4

// reset values
`define BALU_ACC_RST 8'h00
`define BALU_B_RST 8'h00
`define BALU_DATA_POINTER_RST 16'h0000

// flag bit positions in the status byte
`define BALU_FLAG_CY 7
`define BALU_FLAG_AC 6
`define BALU_FLAG_OV 2

`endif

// ---- hdl/balu_pkg.sv ----
`default_nettype none
package balu_pkg;

  // operation selected by the decoder
  typedef enum logic [3:0] {
    BALU_OP_ADD = 4'h0,
    BALU_OP_SUM_WITH_CARRY_IN = 4'h1,
    BALU_OP_SUBTRACT_WITH_BORROW = 4'h2,
    BALU_OP_INC = 4'h3,
    BALU_OP_STEPDN = 4'h4,
    BALU_OP_INCPTR = 4'h5,
    BALU_OP_PROD = 4'h6,
    BALU_OP_DIVIDE = 4'h7,
    BALU_OP_BCD = 4'h8,
    BALU_OP_AND = 4'h9,
    BALU_OP_OR = 4'hA,
    BALU_OP_XOR = 4'hB
  } balu_op_type;

  // where the second operand comes from
  typedef enum logic [2:0] {
    BALU_SRC_BANK = 3'h0,
    BALU_SRC_DIRECT = 3'h1,
    BALU_SRC_INDIRECT = 3'h2,
    BALU_SRC_IMM = 3'h3,
    BALU_SRC_ACC = 3'h4
  } balu_src_type;

  // where the result goes
  typedef enum logic [1:0] {
    BALU_DST_ACC = 2'h0,
    BALU_DST_OPERAND = 2'h1,
    BALU_DST_PTR = 2'h2
  } balu_dst_type;

  // execution sequencer
  typedef enum logic [0:0] {
    BALU_ST_IDLE = 1'b0,
    BALU_ST_BUSY = 1'b1
  } balu_state_type;

endpackage
`default_nettype wire

// ---- verif/balu_core_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ********
// checker
// ********
module balu_core_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // issue side
  input wire logic issueValid,
  input wire logic issueReady,
  input wire balu_pkg::balu_op_type issueOp,
  input wire balu_pkg::balu_src_type issueSrc,
  input wire balu_pkg::balu_dst_type issueDst,
  input wire logic [7:0] operandByte,
  input wire logic [7:0] immByte,
  // completion and state
  input wire logic doneValid,
  input wire logic [2:0] doneCycles,
  input wire logic resultWrite,
  input wire logic [7:0] accOut,
  input wire logic [15:0] dataPointerOut,
  input wire logic carryOut
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  logic take;
  logic keepCy;
  logic [2:0] expCyc;
  logic [8:0] addSum;
  // decode of the offered instruction, expected cycle count
  always_comb begin
    take = issueValid && issueReady;
    keepCy = issueOp inside {balu_pkg::BALU_OP_AND, balu_pkg::BALU_OP_OR,
      balu_pkg::BALU_OP_XOR, balu_pkg::BALU_OP_INC, balu_pkg::BALU_OP_STEPDN};
    expCyc = 3'h1;
    if (issueOp == balu_pkg::BALU_OP_INCPTR) expCyc = 3'h2;
    if (keepCy && issueSrc == balu_pkg::BALU_SRC_IMM && issueDst == balu_pkg::BALU_DST_OPERAND)
      expCyc = 3'h2;
    if (issueOp inside {balu_pkg::BALU_OP_PROD, balu_pkg::BALU_OP_DIVIDE}) expCyc = 3'h4;
    addSum = {1'b0, accOut} + ((issueSrc == balu_pkg::BALU_SRC_IMM) ? immByte : operandByte);
  end
  done_one_a: assert property (
    take && expCyc == 3'h1 |=> ##1 doneValid && issueReady && doneCycles == 3'h1)
    else $error("one-cycle op late");
  done_two_a: assert property (
    take && expCyc == 3'h2 |=> (!doneValid && !issueReady)[*2] ##1
    doneValid && doneCycles == 3'h2)
    else $error("two-cycle op timing");
  done_four_a: assert property (
    take && expCyc == 3'h4 |=> (!doneValid && !issueReady)[*4] ##1
    doneValid && doneCycles == 3'h4)
    else $error("four-cycle op timing");
  done_pulse_a: assert property (doneValid && !take |=> !doneValid)
    else $error("done not a pulse");
  write_done_a: assert property (resultWrite |-> doneValid)
    else $error("write without done");
  logic_carry_a: assert property (
    take && keepCy |=> ##1 $stable(carryOut) ##1 $stable(carryOut))
    else $error("carry changed");
  add_sum_a: assert property (
    take && issueOp == balu_pkg::BALU_OP_ADD |=> ##1 {carryOut, accOut} == $past(addSum, 2))
    else $error("add result wrong");
  mul_carry_a: assert property (doneValid && doneCycles == 3'h4 |-> !carryOut)
    else $error("carry not cleared");
  ptr_step_a: assert property (
    take && issueOp == balu_pkg::BALU_OP_INCPTR |=> ##2
    dataPointerOut == $past(dataPointerOut, 3) + 16'h0001)
    else $error("pointer step wrong");
  // main scenarios reached
  cover property (take && issueOp == balu_pkg::BALU_OP_PROD);
  cover property (take && issueOp == balu_pkg::BALU_OP_INCPTR);
  cover property (resultWrite && doneCycles == 3'h2);
endmodule
bind balu_core balu_core_chk i_chk (.mclk(mclk), .rst_b(rst_b), .issueValid(issueValid),
  .issueReady(issueReady), .issueOp(issueOp), .issueSrc(issueSrc), .issueDst(issueDst),
  .operandByte(operandByte), .immByte(immByte), .doneValid(doneValid),
  .doneCycles(doneCycles), .resultWrite(resultWrite), .accOut(accOut),
  .dataPointerOut(dataPointerOut), .carryOut(carryOut));
`default_nettype wire

// ---- verif/byte_alu_arith_logic_ops_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, g, x); end end
module byte_alu_arith_logic_ops_tb;
  typedef struct {logic [1:0] len; logic [2:0] cyc; logic [7:0] acc; logic cy; logic wr;
    logic [7:0] res; logic [15:0] ptr; logic ac; logic ov; logic [7:0] b;} balu_exp_type;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic issueValid = 1'b0;
  balu_pkg::balu_op_type issueOp = balu_pkg::BALU_OP_ADD;
  balu_pkg::balu_src_type issueSrc = balu_pkg::BALU_SRC_BANK;
  balu_pkg::balu_dst_type issueDst = balu_pkg::BALU_DST_ACC;
  logic [7:0] operandByte = 8'h00;
  logic [7:0] immByte = 8'h00;
  logic issueReady, doneValid, resultWrite, carryOut, auxCarryOut, overflowOut;
  logic [1:0] doneLength;
  logic [2:0] doneCycles;
  logic [7:0] resultByte, accOut, bRegOut;
  logic [15:0] dataPointerOut;
  logic [7:0] mAcc = 8'h00;
  logic mCy = 1'b0;
  logic mAc = 1'b0;
  logic mOv = 1'b0;
  logic [7:0] mB = 8'h00;
  logic [15:0] mPtr = 16'h0000;
  int seed = 95;
  int error_cnt = 0;
  int checked = 0;
  int cycCnt = 0;
  balu_exp_type expQ[$];
  balu_exp_type got;
  balu_core i_dut (.mclk(mclk), .rst_b(rst_b), .issueValid(issueValid), .issueReady(issueReady),
    .issueOp(issueOp), .issueSrc(issueSrc), .issueDst(issueDst), .operandByte(operandByte),
    .immByte(immByte), .doneValid(doneValid), .doneLength(doneLength), .doneCycles(doneCycles),
    .resultWrite(resultWrite), .resultByte(resultByte), .accOut(accOut), .bRegOut(bRegOut),
    .dataPointerOut(dataPointerOut), .carryOut(carryOut), .auxCarryOut(auxCarryOut),
    .overflowOut(overflowOut));
  // ********
  // stimulus
  // ********
  initial begin
    forever #20 mclk = ~mclk;
  end
  // offer one instruction, note what it must give, wait until the core is ready again
  task automatic run(input balu_pkg::balu_op_type op, input balu_pkg::balu_src_type s,
    input balu_pkg::balu_dst_type d, input logic [7:0] o, input logic [7:0] im);
    balu_exp_type e;
    logic [8:0] t;
    logic [7:0] v;
    logic [7:0] x;
    int n;
    issueValid <= 1'b1;
    issueOp <= op;
    issueSrc <= s;
    issueDst <= d;
    operandByte <= o;
    immByte <= im;
    v = (s == balu_pkg::BALU_SRC_IMM) ? im : ((s == balu_pkg::BALU_SRC_ACC) ? mAcc : o);
    x = (d == balu_pkg::BALU_DST_OPERAND) ? o : mAcc;
    e.len = (s == balu_pkg::BALU_SRC_DIRECT || s == balu_pkg::BALU_SRC_IMM) ? 2'h2 : 2'h1;
    e.cyc = 3'h1;
    e.wr = 1'b0;
    e.res = 8'h00;
    case (op)
      balu_pkg::BALU_OP_ADD, balu_pkg::BALU_OP_SUM_WITH_CARRY_IN: begin
        t = {1'b0, mAcc} + v + (op == balu_pkg::BALU_OP_SUM_WITH_CARRY_IN && mCy);
        mAc = ({1'b0, mAcc[3:0]} + v[3:0] + (op == balu_pkg::BALU_OP_SUM_WITH_CARRY_IN && mCy)) > 15;
        mOv = (mAcc[7] == v[7]) && (t[7] != mAcc[7]);
        {mCy, mAcc} = t;
      end
      balu_pkg::BALU_OP_SUBTRACT_WITH_BORROW: begin
        t = {1'b0, mAcc} - v - mCy;
        mAc = mAcc[3:0] < ({1'b0, v[3:0]} + mCy);
        mOv = (mAcc[7] != v[7]) && (t[7] != mAcc[7]);
        {mCy, mAcc} = t;
      end
      balu_pkg::BALU_OP_INC, balu_pkg::BALU_OP_STEPDN: begin
        t = (op == balu_pkg::BALU_OP_INC) ? v + 8'h01 : v - 8'h01;
        if (d == balu_pkg::BALU_DST_OPERAND) {e.wr, e.res} = {1'b1, t[7:0]};
        else mAcc = t[7:0];
      end
      balu_pkg::BALU_OP_INCPTR: {mPtr, e.cyc} = {mPtr + 16'h0001, 3'h2};
      balu_pkg::BALU_OP_PROD: begin
        {mB, mAcc} = mAcc * o;
        {mCy, mOv, e.cyc} = {1'b0, (mB != 8'h00), 3'h4};
      end
      balu_pkg::BALU_OP_DIVIDE: begin
        {mAcc, mB} = (o == 8'h00) ? 16'h0000 : {mAcc / o, mAcc % o};
        {mCy, mOv, e.cyc} = {1'b0, (o == 8'h00), 3'h4};
      end
      balu_pkg::BALU_OP_BCD: begin
        t = {1'b0, mAcc};
        if (t[3:0] > 9 || mAc) t = t + 9'h006;
        if (t[8:4] > 9 || mCy) t = t + 9'h060;
        {mCy, mAcc} = {mCy | t[8], t[7:0]};
      end
      default: begin
        t = {1'b0, (op == balu_pkg::BALU_OP_AND) ? (x & v) : (op == balu_pkg::BALU_OP_OR) ?
          (x | v) : (x ^ v)};
        if (d == balu_pkg::BALU_DST_OPERAND) begin
          {e.wr, e.res} = {1'b1, t[7:0]};
          e.len = (s == balu_pkg::BALU_SRC_IMM) ? 2'h3 : 2'h2;
          e.cyc = (s == balu_pkg::BALU_SRC_IMM) ? 3'h2 : 3'h1;
        end else mAcc = t[7:0];
      end
    endcase
    {e.acc, e.cy, e.ptr, e.ac, e.ov, e.b} = {mAcc, mCy, mPtr, mAc, mOv, mB};
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (issueReady !== 1'b1 && n < 10);
    expQ.push_back(e);
  endtask
  // take the oldest note whenever a completion shows
  always @(posedge mclk) begin
    if (rst_b && doneValid === 1'b1) begin
      `CHK(expQ.size() > 0, 1'b1)
      if (expQ.size() > 0) begin
        got = expQ.pop_front();
        `CHK(doneLength, got.len)
        `CHK(doneCycles, got.cyc)
        `CHK(accOut, got.acc)
        `CHK(carryOut, got.cy)
        `CHK(auxCarryOut, got.ac)
        `CHK(overflowOut, got.ov)
        `CHK(bRegOut, got.b)
        `CHK(dataPointerOut, got.ptr)
        `CHK(resultWrite, got.wr)
        if (got.wr) `CHK(resultByte, got.res)
      end
    end
  end
  // hang guard, a few hundred cycles are expected
  always @(posedge mclk) begin
    cycCnt++;
    if (cycCnt > 3000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // every form of every op, twice with random bytes, back to back
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    `CHK(issueReady, 1'b1)
    `CHK(accOut, 8'h00)
    for (int r = 0; r < 2; r++) begin
      for (int k = 0; k < 12; k++) begin
        for (int s = 0; s < 6; s++) begin
          if ((k > 4 && k < 9 && s > 0) || (s == 5 && k < 9)) continue;
          // step up or down has no immediate form
          if ((s == 4 && k < 9 && k != 3 && k != 4) || ((k == 3 || k == 4) && s == 3)) continue;
          run(balu_pkg::balu_op_type'(4'(k)), balu_pkg::balu_src_type'(3'((s == 5) ? 3 : s)),
            balu_pkg::balu_dst_type'(2'((s == 5 || (k > 8 && s == 4) ||
            ((k == 3 || k == 4) && s < 4)) ? 1 : 0)), 8'($random(seed)), 8'($random(seed)));
        end
      end
    end
    run(balu_pkg::BALU_OP_AND, balu_pkg::BALU_SRC_IMM, balu_pkg::BALU_DST_ACC, 8'h00, 8'h00);
    run(balu_pkg::BALU_OP_OR, balu_pkg::BALU_SRC_IMM, balu_pkg::BALU_DST_ACC, 8'h00, 8'h38);
    run(balu_pkg::BALU_OP_ADD, balu_pkg::BALU_SRC_IMM, balu_pkg::BALU_DST_ACC, 8'h00, 8'h29);
    run(balu_pkg::BALU_OP_BCD, balu_pkg::BALU_SRC_BANK, balu_pkg::BALU_DST_ACC, 8'h00, 8'h00);
    run(balu_pkg::BALU_OP_PROD, balu_pkg::BALU_SRC_BANK, balu_pkg::BALU_DST_ACC, 8'h05, 8'h00);
    run(balu_pkg::BALU_OP_DIVIDE, balu_pkg::BALU_SRC_BANK, balu_pkg::BALU_DST_ACC, 8'h00, 8'h00);
    issueValid <= 1'b0;
    repeat (8) @(posedge mclk);
    `CHK(expQ.size(), 0)
    finish_test();
  end
endmodule
`default_nettype wire
